// ### src/dasr_map.vh
// Constants for the dual converter serial readout block.
// Assumes inclusion by bare name from the design files.
`ifndef DASR_MAP_VH
`define DASR_MAP_VH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define DASR_RES_W 14
`define DASR_WORD_W 16
`define DASR_CNT_W 6
`define DASR_CNT_ZERO 6'h00
`define DASR_CNT_ONE 6'h01
`define DASR_CNT_PD_LO 6'h02
`define DASR_CNT_PD_HI 6'h0a
`define DASR_CNT_CONV 6'h10
`define DASR_CNT_END 6'h20
`define DASR_CNT_MAX 6'h3f

// ----------------------------------------------------------------
// Power states
// ----------------------------------------------------------------
`define DASR_PWR_W 2
`define DASR_PWR_NORMAL 2'h0
`define DASR_PWR_PARTIAL 2'h1
`define DASR_PWR_FULL 2'h2

`endif

// ### src/dasr_sync.v
// Two-flop synchroniser with edge detection on the second stage.
// Assumes an input from outside the i_clk domain.
`timescale 1ns/10ps
`include "dasr_map.vh"

module dasr_sync
#(
    parameter RESET_VAL = 1'b0
)
(
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    // Pin
    input wire i_pin,
    // Synchronised level and edges
    output reg o_level,
    output wire o_rise,
    output wire o_fall
);

    reg meta_q;
    reg last_q;

    // Only the second stage and its delayed copy are looked at
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta_q <= RESET_VAL;
            o_level <= RESET_VAL;
            last_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= i_pin;
            o_level <= meta_q;
            last_q <= o_level;
        end
    end

    assign o_rise = o_level & ~last_q;
    assign o_fall = ~o_level & last_q;

endmodule // dasr_sync

// ### src/dasr_readout.v
// Serial control and readout of a dual simultaneous-sampling converter.
// Assumes the host drives the select and serial clock; both are sampled
// on i_clk, so the serial clock must be well below a quarter of i_clk.
`timescale 1ns/10ps
`include "dasr_map.vh"

module dasr_readout
(
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    // Host pins
    input wire i_select_n,
    input wire i_sclk,
    // Converter inputs, treated as already quantised samples
    input wire [`DASR_RES_W-1:0] i_sample_a,
    input wire [`DASR_RES_W-1:0] i_sample_b,
    // Serial data lines
    output reg o_result_line_a,
    output reg o_result_line_a_oe,
    output reg o_result_line_b,
    output reg o_result_line_b_oe,
    // Status
    output reg o_hold,
    output reg o_busy,
    output reg [`DASR_PWR_W-1:0] o_power
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire sel_rise;
    wire sel_fall;
    wire sclk_rise;
    wire sclk_fall;

    dasr_sync #(.RESET_VAL(1'b1)) u_sel (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_select_n),
        .o_level(),
        .o_rise(sel_rise),
        .o_fall(sel_fall)
    );

    dasr_sync #(.RESET_VAL(1'b0)) u_sclk (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_sclk),
        .o_level(),
        .o_rise(sclk_rise),
        .o_fall(sclk_fall)
    );

    // ----------------------------------------------------------------
    // Frame state
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_ACTIVE = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [1:0] state_q;
    reg [`DASR_CNT_W-1:0] falls_q;
    reg [`DASR_RES_W-1:0] samp_a_q;
    reg [`DASR_RES_W-1:0] samp_b_q;
    reg [`DASR_RES_W-1:0] res_a_q;
    reg [`DASR_RES_W-1:0] res_b_q;
    reg [`DASR_WORD_W-1:0] shift_a_q;
    reg [`DASR_WORD_W-1:0] shift_b_q;
    reg conv_done_q;
    reg pending_track_q;

    // Power step taken when select rises inside the abort window
    function [`DASR_PWR_W-1:0] pwr_step;
        input [`DASR_PWR_W-1:0] cur;
        input [`DASR_CNT_W-1:0] cnt;
        begin
            pwr_step = cur;
            if (cnt >= `DASR_CNT_PD_LO && cnt < `DASR_CNT_PD_HI)
            begin
                if (cur == `DASR_PWR_NORMAL)
                    pwr_step = `DASR_PWR_PARTIAL;
                else
                    pwr_step = `DASR_PWR_FULL;
            end
            else if (cnt >= `DASR_CNT_PD_HI)
                pwr_step = `DASR_PWR_NORMAL;
            // Below two falling edges the state is left alone
        end
    endfunction

    // Word of a frame, first or second: the given result behind two leading zeros
    function [`DASR_WORD_W-1:0] frame_word;
        input [`DASR_RES_W-1:0] res;
        begin
            frame_word = {{(`DASR_WORD_W-`DASR_RES_W){1'b0}}, res};
        end
    endfunction

    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q <= ST_IDLE;
            falls_q <= `DASR_CNT_ZERO;
            samp_a_q <= {`DASR_RES_W{1'b0}};
            samp_b_q <= {`DASR_RES_W{1'b0}};
            res_a_q <= {`DASR_RES_W{1'b0}};
            res_b_q <= {`DASR_RES_W{1'b0}};
            shift_a_q <= {`DASR_WORD_W{1'b0}};
            shift_b_q <= {`DASR_WORD_W{1'b0}};
            conv_done_q <= 1'b0;
            pending_track_q <= 1'b0;
            o_result_line_a <= 1'b0;
            o_result_line_a_oe <= 1'b0;
            o_result_line_b <= 1'b0;
            o_result_line_b_oe <= 1'b0;
            o_hold <= 1'b0;
            o_busy <= 1'b0;
            o_power <= `DASR_PWR_NORMAL;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (sel_fall)
                    begin
                        // Hold, sample, start and drive first zero
                        state_q <= ST_ACTIVE;
                        falls_q <= `DASR_CNT_ZERO;
                        samp_a_q <= i_sample_a;
                        samp_b_q <= i_sample_b;
                        // Previous result goes out this frame
                        shift_a_q <= frame_word(res_a_q);
                        shift_b_q <= frame_word(res_b_q);
                        conv_done_q <= 1'b0;
                        pending_track_q <= 1'b0;
                        o_hold <= 1'b1;
                        o_busy <= 1'b1;
                        o_result_line_a <= 1'b0;
                        o_result_line_b <= 1'b0;
                        o_result_line_a_oe <= 1'b1;
                        o_result_line_b_oe <= 1'b1;
                    end
                end
                ST_ACTIVE, ST_DONE:
                begin
                    if (sel_rise)
                    begin
                        // Abort, tri-state, update power state
                        state_q <= ST_IDLE;
                        o_result_line_a_oe <= 1'b0;
                        o_result_line_b_oe <= 1'b0;
                        o_busy <= 1'b0;
                        o_hold <= 1'b0;
                        o_power <= pwr_step(o_power, falls_q);
                        if (conv_done_q)
                        begin
                            res_a_q <= samp_a_q;
                            res_b_q <= samp_b_q;
                        end
                    end
                    else if (state_q == ST_ACTIVE)
                    begin
                        if (sclk_fall)
                        begin
                            falls_q <= falls_q + `DASR_CNT_ONE;
                            // Last result bit leaves on the fifteenth fall
                            o_result_line_a <= shift_a_q[`DASR_WORD_W-2];
                            o_result_line_b <= shift_b_q[`DASR_WORD_W-2];
                            shift_a_q <= {shift_a_q[`DASR_WORD_W-2:0], 1'b0};
                            shift_b_q <= {shift_b_q[`DASR_WORD_W-2:0], 1'b0};
                            if (falls_q == `DASR_CNT_CONV - `DASR_CNT_ONE)
                            begin
                                // Conversion finished; swap channels
                                conv_done_q <= 1'b1;
                                pending_track_q <= 1'b1;
                                o_busy <= 1'b0;
                                shift_a_q <= frame_word(res_b_q);
                                shift_b_q <= frame_word(res_a_q);
                                o_result_line_a <= 1'b0;
                                o_result_line_b <= 1'b0;
                            end
                            if (falls_q == `DASR_CNT_END - `DASR_CNT_ONE)
                            begin
                                // Tri-state and stay there until next frame
                                state_q <= ST_DONE;
                                o_result_line_a_oe <= 1'b0;
                                o_result_line_b_oe <= 1'b0;
                            end
                        end
                        if (sclk_rise && pending_track_q)
                        begin
                            // Back to track after the sixteenth fall
                            pending_track_q <= 1'b0;
                            o_hold <= 1'b0;
                        end
                    end
                    else if (sclk_rise && pending_track_q)
                    begin
                        pending_track_q <= 1'b0;
                        o_hold <= 1'b0;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // dasr_readout

// ### test/dasr_chk_sva.sv
// Concurrent checks on the readout block's ports.
// Assumes pins pass a two-flop synchroniser, so answers lag by a few clocks.
`timescale 1ns/10ps
`include "dasr_map.vh"

module dasr_chk (
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    // Host pins
    input wire i_select_n,
    input wire i_sclk,
    // Outputs watched
    input wire o_result_line_a,
    input wire o_result_line_a_oe,
    input wire o_result_line_b,
    input wire o_result_line_b_oe,
    input wire o_hold,
    input wire o_busy,
    input wire [`DASR_PWR_W-1:0] o_power
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    property p_start;
        $fell(i_select_n) |-> ##[2:6] (o_result_line_a_oe && o_result_line_b_oe && o_hold);
    endproperty
    a_start: assert property (p_start) else $error("frame start missed");
    property p_stop;
        $rose(i_select_n) |-> ##[2:6] (!o_result_line_a_oe && !o_result_line_b_oe);
    endproperty
    a_stop: assert property (p_stop) else $error("lines still driven");
    property p_lead;
        $rose(o_result_line_a_oe) |-> (!o_result_line_a && !o_result_line_b);
    endproperty
    a_lead: assert property (p_lead) else $error("first bit not zero");
    property p_busy;
        $rose(o_busy) |-> ##[0:2] o_hold;
    endproperty
    a_busy: assert property (p_busy) else $error("no hold in conversion");
    // Hold must release on the first serial clock rise after the conversion
    property p_track;
        !o_busy && o_hold && o_result_line_a_oe && $rose(i_sclk) |-> ##[1:6] !o_hold;
    endproperty
    a_track: assert property (p_track) else $error("hold not released");
    property p_pwr_cause;
        $changed(o_power) |-> (i_select_n && $past(i_select_n, 2));
    endproperty
    a_pwr_cause: assert property (p_pwr_cause) else $error("power moved mid frame");
    property p_pwr_path;
        $changed(o_power) && o_power == `DASR_PWR_FULL |-> $past(o_power) == `DASR_PWR_PARTIAL;
    endproperty
    a_pwr_path: assert property (p_pwr_path) else $error("full without partial");
    property p_quiet;
        !o_result_line_a_oe && !i_select_n && !$past(i_select_n, 6) |=> !o_result_line_a_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("line driven after end");
    c_frame: cover property ($rose(o_result_line_a_oe));
    c_full: cover property (o_power == `DASR_PWR_FULL);
    c_end: cover property ($fell(o_result_line_a_oe) && !i_select_n);
endmodule // dasr_chk

bind dasr_readout dasr_chk chk (.i_clk(i_clk), .i_reset(i_reset), .i_select_n(i_select_n),
    .i_sclk(i_sclk), .o_result_line_a(o_result_line_a), .o_result_line_a_oe(o_result_line_a_oe),
    .o_result_line_b(o_result_line_b), .o_result_line_b_oe(o_result_line_b_oe),
    .o_hold(o_hold), .o_busy(o_busy), .o_power(o_power));

// ### test/dasr_host.sv
// Host serial port model: frames of n serial clock cycles.
// Assumes a 64 ns serial clock that stands low between frames.
`timescale 1ns/10ps

module dasr_host (
    // Pins towards the device
    output reg o_select_n,
    output reg o_sclk,
    input wire i_line_a,
    input wire i_oe_a,
    input wire i_line_b,
    input wire i_oe_b
);
    reg [33:0] word_a;
    reg [33:0] word_b;
    reg [33:0] word_r;
    initial
    begin
        o_select_n = 1'b1;
        o_sclk = 1'b0;
    end
    task frame(input integer n);
        integer k;
        begin
            word_a = 34'h0;
            word_b = 34'h0;
            word_r = 34'h0;
            o_select_n = 1'b0;
            #32;
            for (k = 0; k < n; k = k + 1)
            begin
                // Slow host copy of line A taken at each rising edge
                word_r = {word_r[32:0], i_oe_a ? i_line_a : 1'bx};
                o_sclk = 1'b1;
                #32;
                // Sample just before the falling edge; a released line reads unknown
                word_a = {word_a[32:0], i_oe_a ? i_line_a : 1'bx};
                word_b = {word_b[32:0], i_oe_b ? i_line_b : 1'bx};
                o_sclk = 1'b0;
                #32;
            end
            o_select_n = 1'b1;
            #400;
        end
    endtask
endmodule // dasr_host

// ### test/dasr_readout_test.sv
// Self-checking bench for the serial readout block.
// Assumes the host model makes every frame and records both lines.
`timescale 1ns/10ps
`include "dasr_map.vh"

module dasr_readout_test;
    reg i_clk;
    reg i_reset;
    reg [`DASR_RES_W-1:0] i_sample_a;
    reg [`DASR_RES_W-1:0] i_sample_b;
    wire select_n;
    wire sclk;
    wire line_a;
    wire oe_a;
    wire line_b;
    wire oe_b;
    wire [`DASR_PWR_W-1:0] power;
    wire hold;
    wire busy;
    integer fails;
    integer checks_done;
    dasr_readout uut (.i_clk(i_clk), .i_reset(i_reset), .i_select_n(select_n), .i_sclk(sclk),
        .i_sample_a(i_sample_a), .i_sample_b(i_sample_b), .o_result_line_a(line_a),
        .o_result_line_a_oe(oe_a), .o_result_line_b(line_b), .o_result_line_b_oe(oe_b),
        .o_hold(hold), .o_busy(busy), .o_power(power));
    dasr_host host (.o_select_n(select_n), .o_sclk(sclk), .i_line_a(line_a), .i_oe_a(oe_a),
        .i_line_b(line_b), .i_oe_b(oe_b));
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task check(input [33:0] got, input [33:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                fails = fails + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d fails %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task t_first;
        begin
            host.frame(16);
            check(host.word_a, 34'h0);
            check(host.word_b, 34'h0);
        end
    endtask
    task t_dual;
        begin
            @(negedge i_clk);
            i_sample_a = 14'h05c3;
            i_sample_b = 14'h3ffe;
            // Status probes sit between serial clock edges, clear of sync lag
            fork
                host.frame(34);
                begin
                    #600;
                    check({32'h0, hold, busy}, {32'h0, 2'h3});
                    #440;
                    check({32'h0, hold, busy}, {32'h0, 2'h2});
                    #60;
                    check({32'h0, hold, busy}, 34'h0);
                end
            join
            check(host.word_a, {2'h0, 14'h2a5c, 2'h0, 14'h1d37, 2'hx});
            check(host.word_b, {2'h0, 14'h1d37, 2'h0, 14'h2a5c, 2'hx});
        end
    endtask
    task t_power;
        begin
            @(negedge i_clk);
            i_sample_a = 14'h0f0f;
            i_sample_b = 14'h3001;
            host.frame(5);
            check({32'h0, power}, {32'h0, `DASR_PWR_PARTIAL});
            check({33'h0, oe_a}, 34'h0);
            host.frame(5);
            check({32'h0, power}, {32'h0, `DASR_PWR_FULL});
            host.frame(1);
            check({32'h0, power}, {32'h0, `DASR_PWR_FULL});
            host.frame(16);
            check({32'h0, power}, {32'h0, `DASR_PWR_NORMAL});
            check(host.word_a, {20'h0, 14'h05c3});
            check(host.word_b, {20'h0, 14'h3ffe});
            check(host.word_r, {20'h0, 14'h05c3});
            check({32'h0, hold, busy}, 34'h0);
        end
    endtask
    initial
    begin
        #60000;
        fails = fails + 1;
        end_sim;
    end
    initial
    begin
        fails = 0;
        checks_done = 0;
        i_reset = 1'b1;
        i_sample_a = 14'h2a5c;
        i_sample_b = 14'h1d37;
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        t_first;
        t_dual;
        t_power;
        end_sim;
    end
endmodule // dasr_readout_test
